// File: verilog/adc_ctrl.v
/*
 * Converter control block: APB register file, trigger and scan sequencer,
 * reference and channel selection, limit window check on each result.
 * Assumes the analog front end answers COMP_IN within one cycle of a
 * change of DAC_CODE; HW_TRIGGER and COMP_IN are asynchronous pins.
 */
`timescale 1ns/1ps
`include "adc_ctrl_defs.vh"

module adc_ctrl (
    input  wire        SYS_CLK,
    input  wire        RESET,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    input  wire        HW_TRIGGER,
    input  wire        COMP_IN,
    output wire [4:0]  CHANNEL_SEL,
    output wire        INTERNAL_SRC,
    output wire [1:0]  POS_REF_SEL,
    output wire        NEG_REF_SEL,
    output wire        COMP_ENABLE,
    output wire        SAMPLE,
    output wire [9:0]  DAC_CODE,
    output reg         CONV_END_IRQ
);

    // ****************************************
    // Declarations
    // ****************************************
    localparam F_IDLE = 2'h0;
    localparam F_TRIG = 2'h1;
    localparam F_STAB = 2'h2;
    localparam F_CONV = 2'h3;
    localparam [31:0] STAB_LOAD = `STAB_CYCLES - 1;

    reg  [7:0]  mode0_q;
    reg  [7:0]  trig_q;
    reg  [7:0]  ref_q;
    reg  [7:0]  upper_q;
    reg  [7:0]  lower_q;
    reg  [7:0]  chan_q;
    reg  [15:0] result_q;
    reg         flag_q;
    reg         gate_q;
    reg  [1:0]  fsm_q;
    reg  [1:0]  idx_q;
    reg  [7:0]  stab_q;
    reg         go_q;
    reg         start_clr;
    reg         win_hit;
    reg  [2:0]  trig_s;
    reg         trig_lvl_q;
    reg  [2:0]  comp_s;
    reg         comp_lvl_q;
    reg         win_q;
    reg         evt_q;
    wire        setup;
    wire        wr;
    wire        mapped;
    wire        cfg_wr;
    wire        trig_edge;
    wire        sar_done;
    wire        conv_tick;
    wire        cfg_ok;
    wire        scan;
    wire        hw_mode;
    wire        wait_mode;
    wire        oneshot;
    wire        run_ok;
    wire [4:0]  code;
    wire [4:0]  cur_code;
    wire [7:0]  res_hi;
    wire [7:0]  status;

    // ****************************************
    // Decoding helpers
    // ****************************************
    function chan_valid;
        input       iss;
        input [4:0] c;
        begin
            if (iss)
                chan_valid = (c == `CODE_TEMP_SENSOR) || (c == `CODE_INT_REF);
            else
                chan_valid = (c <= `CODE_LAST_LOW) ||
                             (c >= `CODE_FIRST_HIGH && c <= `CODE_AMP_OUT);
        end
    endfunction

    function is_mapped;
        input [11:0] a;
        begin
            case (a)
                `OFF_MODE_CTRL_0, `OFF_TRIGGER_CTRL, `OFF_REFERENCE_CTRL,
                `OFF_UPPER_LIMIT, `OFF_LOWER_LIMIT, `OFF_CHANNEL_SELECT,
                `OFF_RESULT, `OFF_STATUS, `OFF_CLOCK_GATE: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    // ****************************************
    // Configuration decode
    // ****************************************
    assign scan      = mode0_q[`M0_SCAN];
    assign hw_mode   = trig_q[`TR_MODE_HI];
    assign wait_mode = trig_q[`TR_MODE_HI] & trig_q[`TR_MODE_LO];
    assign oneshot   = trig_q[`TR_ONESHOT];
    assign code      = chan_q[`CS_CODE_HI:0];
    assign cur_code  = scan ? (code + {3'h0, idx_q}) : code;

    // Prohibited settings never start a conversion
    assign cfg_ok = (ref_q[`RF_POS_HI:`RF_POS_LO] != `POS_REF_BAD) &&
                    !mode0_q[`M0_LV_HI] &&
                    !(ref_q[`RF_POS_HI:`RF_POS_LO] == `POS_REF_INTERNAL &&
                      chan_q[`CS_INTERNAL]) &&
                    chan_valid(chan_q[`CS_INTERNAL], code) &&
                    (!scan || (!chan_q[`CS_INTERNAL] &&
                     chan_valid(1'b0, code + 5'h03) &&
                     (code == 5'h00 || code >= `CODE_FIRST_HIGH)));

    assign run_ok = gate_q & mode0_q[`M0_START] & mode0_q[`M0_CMP_EN] & cfg_ok;

    assign CHANNEL_SEL  = cur_code;
    assign INTERNAL_SRC = chan_q[`CS_INTERNAL];
    assign POS_REF_SEL  = ref_q[`RF_POS_HI:`RF_POS_LO];
    assign NEG_REF_SEL  = ref_q[`RF_NEG];
    assign COMP_ENABLE  = mode0_q[`M0_CMP_EN] & gate_q;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // A change counts once stages two and three agree
    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            trig_s     <= 3'h0;
            trig_lvl_q <= 1'b0;
            comp_s     <= 3'h0;
            comp_lvl_q <= 1'b0;
        end else begin
            trig_s <= {trig_s[1:0], HW_TRIGGER};
            comp_s <= {comp_s[1:0], COMP_IN};
            if (trig_s[1] == trig_s[2]) begin
                trig_lvl_q <= trig_s[2];
            end
            if (comp_s[1] == comp_s[2]) begin
                comp_lvl_q <= comp_s[2];
            end
        end
    end

    assign trig_edge = (trig_s[1] == trig_s[2]) & trig_s[2] & ~trig_lvl_q;

    // ****************************************
    // APB slave
    // ****************************************
    // Zero wait states; read data is captured in the setup cycle
    assign setup   = PSEL & ~PENABLE;
    assign wr      = PSEL & PENABLE & PWRITE;
    assign mapped  = is_mapped(PADDR);
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;
    assign cfg_wr  = wr & gate_q;
    assign res_hi  = result_q[15:8];
    assign status  = {5'h00, (fsm_q != F_IDLE), ~cfg_ok, flag_q};

    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            PRDATA <= 32'h0000_0000;
        end else if (setup) begin
            case (PADDR)
                `OFF_MODE_CTRL_0:    PRDATA <= {24'h0, gate_q ? mode0_q : 8'h00};
                `OFF_TRIGGER_CTRL:   PRDATA <= {24'h0, gate_q ? trig_q : 8'h00};
                `OFF_REFERENCE_CTRL: PRDATA <= {24'h0, gate_q ? ref_q : 8'h00};
                `OFF_UPPER_LIMIT:    PRDATA <= {24'h0, gate_q ? upper_q : 8'h00};
                `OFF_LOWER_LIMIT:    PRDATA <= {24'h0, gate_q ? lower_q : 8'h00};
                `OFF_CHANNEL_SELECT: PRDATA <= {24'h0, gate_q ? chan_q : 8'h00};
                `OFF_RESULT:         PRDATA <= {16'h0, gate_q ? result_q : 16'h0000};
                `OFF_STATUS:         PRDATA <= {24'h0, status};
                `OFF_CLOCK_GATE:     PRDATA <= {31'h0, gate_q};
                default:             PRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            mode0_q <= `RST_MODE_CTRL_0;
            trig_q  <= `RST_TRIGGER_CTRL;
            ref_q   <= `RST_REFERENCE_CTRL;
            upper_q <= `RST_UPPER_LIMIT;
            lower_q <= `RST_LOWER_LIMIT;
            chan_q  <= `RST_CHANNEL_SELECT;
            gate_q  <= 1'b0;
        end else begin
            if (wr && PADDR == `OFF_CLOCK_GATE) begin
                gate_q <= PWDATA[0];
            end
            if (cfg_wr) begin
                case (PADDR)
                    `OFF_MODE_CTRL_0:    mode0_q <= PWDATA[7:0] & `MASK_MODE_CTRL_0;
                    `OFF_TRIGGER_CTRL:   trig_q  <= PWDATA[7:0] & `MASK_TRIGGER_CTRL;
                    // Rewrite of a live reference relies on software going via 00
                    `OFF_REFERENCE_CTRL: ref_q   <= PWDATA[7:0] & `MASK_REFERENCE_CTRL;
                    `OFF_UPPER_LIMIT:    upper_q <= PWDATA[7:0];
                    `OFF_LOWER_LIMIT:    lower_q <= PWDATA[7:0];
                    `OFF_CHANNEL_SELECT: chan_q  <= PWDATA[7:0] & `MASK_CHANNEL_SELECT;
                    default: ;
                endcase
            end
            // Hardware clear after a one-shot pass loses to a software write
            if (start_clr && !(cfg_wr && PADDR == `OFF_MODE_CTRL_0)) begin
                mode0_q[`M0_START] <= 1'b0;
            end
        end
    end

    // ****************************************
    // Window check
    // ****************************************
    // Compares the upper eight result bits, which both resolutions fill
    always @* begin
        if (ref_q[`RF_OUTSIDE])
            win_hit = (res_hi < lower_q) || (res_hi > upper_q);
        else
            win_hit = (res_hi >= lower_q) && (res_hi <= upper_q);
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            fsm_q        <= F_IDLE;
            idx_q        <= 2'h0;
            stab_q       <= 8'h00;
            go_q         <= 1'b0;
            start_clr    <= 1'b0;
            result_q     <= 16'h0000;
            flag_q       <= 1'b0;
            CONV_END_IRQ <= 1'b0;
        end else begin
            go_q         <= 1'b0;
            start_clr    <= 1'b0;
            CONV_END_IRQ <= evt_q;
            // Set wins over a write-one clear in the same cycle
            if (wr && PADDR == `OFF_STATUS && PWDATA[`ST_FLAG]) begin
                flag_q <= 1'b0;
            end
            if (evt_q) begin
                flag_q <= 1'b1;
            end
            if (!run_ok) begin
                fsm_q <= F_IDLE;
                idx_q <= 2'h0;
            end else begin
                case (fsm_q)
                    F_IDLE: begin
                        idx_q <= 2'h0;
                        // A finished one-shot pass must not restart before start clears
                        if (start_clr) begin
                            fsm_q <= F_IDLE;
                        end else if (hw_mode) begin
                            fsm_q <= F_TRIG;
                        end else begin
                            fsm_q <= F_CONV;
                            go_q  <= 1'b1;
                        end
                    end
                    F_TRIG: begin
                        if (trig_edge) begin
                            if (wait_mode) begin
                                fsm_q  <= F_STAB;
                                stab_q <= STAB_LOAD[7:0];
                            end else begin
                                fsm_q <= F_CONV;
                                go_q  <= 1'b1;
                            end
                        end
                    end
                    F_STAB: begin
                        if (stab_q == 8'h00) begin
                            fsm_q <= F_CONV;
                            go_q  <= 1'b1;
                        end else begin
                            stab_q <= stab_q - 8'h01;
                        end
                    end
                    F_CONV: begin
                        if (sar_done) begin
                            // 8-bit results keep the low byte at zero
                            result_q <= {DAC_CODE, 6'h00} &
                                        (ref_q[`RF_RES8] ? 16'hff00 : 16'hffc0);
                            go_q     <= 1'b1;
                            if (scan && idx_q != `SCAN_LAST_IDX) begin
                                idx_q <= idx_q + 2'h1;
                            end else begin
                                idx_q <= 2'h0;
                                if (oneshot) begin
                                    go_q      <= 1'b0;
                                    fsm_q     <= hw_mode && !wait_mode ? F_TRIG : F_IDLE;
                                    start_clr <= !(hw_mode && !wait_mode);
                                end else if (hw_mode) begin
                                    go_q  <= 1'b0;
                                    fsm_q <= F_TRIG;
                                end
                            end
                        end
                    end
                    default: fsm_q <= F_IDLE;
                endcase
            end
        end
    end

    // Event waits one cycle so the window sees the stored result
    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            win_q <= 1'b0;
        end else begin
            win_q <= (fsm_q == F_CONV) && sar_done && run_ok;
        end
    end

    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            evt_q <= 1'b0;
        end else begin
            evt_q <= win_q & win_hit;
        end
    end

    // ****************************************
    // Conversion engine
    // ****************************************
    conv_clk_div u_div (
        .clk     (SYS_CLK),
        .rst     (RESET),
        .run     (fsm_q == F_CONV),
        .div_sel (mode0_q[`M0_FR_HI:`M0_FR_LO]),
        .tick    (conv_tick)
    );

    sar_core u_sar (
        .clk      (SYS_CLK),
        .rst      (RESET),
        .tick     (conv_tick),
        .go       (go_q),
        .abort    (!run_ok),
        .res8     (ref_q[`RF_RES8]),
        .level2   (mode0_q[`M0_LV_LO]),
        .comp_hi  (comp_lvl_q),
        .sample   (SAMPLE),
        .dac_code (DAC_CODE),
        .done     (sar_done)
    );

endmodule

// File: verilog/adc_ctrl_defs.vh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * converter control block.
 * Assumes a 100 MHz system clock and APB byte addresses of 12 bits.
 */
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_MODE_CTRL_0      12'h000
`define OFF_TRIGGER_CTRL     12'h004
`define OFF_REFERENCE_CTRL   12'h008
`define OFF_UPPER_LIMIT      12'h00c
`define OFF_LOWER_LIMIT      12'h010
`define OFF_CHANNEL_SELECT   12'h014
`define OFF_RESULT           12'h018
`define OFF_STATUS           12'h01c
`define OFF_CLOCK_GATE       12'h020

// ****************************************
// Field positions
// ****************************************
`define M0_START     7
`define M0_SCAN      6
`define M0_FR_HI     5
`define M0_FR_LO     3
`define M0_LV_HI     2
`define M0_LV_LO     1
`define M0_CMP_EN    0
`define TR_MODE_HI   7
`define TR_MODE_LO   6
`define TR_ONESHOT   5
`define RF_POS_HI    7
`define RF_POS_LO    6
`define RF_NEG       5
`define RF_OUTSIDE   3
`define RF_RES8      0
`define CS_INTERNAL  7
`define CS_CODE_HI   4
`define ST_FLAG      0
`define ST_CFG_ERR   1
`define ST_BUSY      2

// ****************************************
// Writable bits and reset values
// ****************************************
`define MASK_MODE_CTRL_0     8'hff
`define MASK_TRIGGER_CTRL    8'he0
`define MASK_REFERENCE_CTRL  8'he9
`define MASK_CHANNEL_SELECT  8'h9f
`define RST_MODE_CTRL_0      8'h00
`define RST_TRIGGER_CTRL     8'h00
`define RST_REFERENCE_CTRL   8'h00
`define RST_UPPER_LIMIT      8'hff
`define RST_LOWER_LIMIT      8'h00
`define RST_CHANNEL_SELECT   8'h00

// ****************************************
// Codes
// ****************************************
`define POS_REF_INTERNAL     2'h2
`define POS_REF_BAD          2'h3
`define CODE_TEMP_SENSOR     5'h00
`define CODE_INT_REF         5'h01
`define CODE_LAST_LOW        5'h03
`define CODE_FIRST_HIGH      5'h10
`define CODE_AMP_OUT         5'h17
`define SCAN_LAST_IDX        2'h3

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS        10
`define STAB_TIME_NS         1000
`define STAB_CYCLES          ((`STAB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DIV_FR0              6'd63
`define DIV_FR1              6'd31
`define DIV_FR2              6'd15
`define DIV_FR3              6'd7
`define DIV_FR4              6'd5
`define DIV_FR5              6'd4
`define DIV_FR6              6'd3
`define DIV_FR7              6'd1
`define SAMPLE_TICKS_N1      4'd9
`define SAMPLE_TICKS_N2      4'd7

`endif

// File: verilog/conv_clk_div.v
/*
 * Conversion clock divider: one-cycle enable pulse at the system clock
 * divided by 64, 32, 16, 8, 6, 5, 4 or 2.
 * Assumes the divide select is steady while enabled.
 */
`timescale 1ns/1ps
`include "adc_ctrl_defs.vh"

module conv_clk_div (
    input  wire       clk,
    input  wire       rst,
    input  wire       run,
    input  wire [2:0] div_sel,
    output reg        tick
);

    reg  [5:0] cnt_q;

    function [5:0] div_limit;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: div_limit = `DIV_FR0;
                3'h1: div_limit = `DIV_FR1;
                3'h2: div_limit = `DIV_FR2;
                3'h3: div_limit = `DIV_FR3;
                3'h4: div_limit = `DIV_FR4;
                3'h5: div_limit = `DIV_FR5;
                3'h6: div_limit = `DIV_FR6;
                default: div_limit = `DIV_FR7;
            endcase
        end
    endfunction

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 6'h00;
            tick  <= 1'b0;
        end else if (!run) begin
            cnt_q <= 6'h00;
            tick  <= 1'b0;
        end else if (cnt_q >= div_limit(div_sel)) begin
            cnt_q <= 6'h00;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 6'h01;
            tick  <= 1'b0;
        end
    end

endmodule

// File: verilog/sar_core.v
/*
 * Successive approximation engine: a sampling phase, then one trial bit
 * per two conversion ticks, most significant first.
 * Assumes the comparator level arrives already synchronised.
 */
`timescale 1ns/1ps
`include "adc_ctrl_defs.vh"

module sar_core (
    input  wire       clk,
    input  wire       rst,
    input  wire       tick,
    input  wire       go,
    input  wire       abort,
    input  wire       res8,
    input  wire       level2,
    input  wire       comp_hi,
    output reg        sample,
    output reg  [9:0] dac_code,
    output reg        done
);

    localparam S_IDLE   = 2'h0;
    localparam S_SAMPLE = 2'h1;
    localparam S_BITS   = 2'h2;

    reg  [1:0] state_q;
    reg  [3:0] cnt_q;
    reg        phase_q;
    reg  [3:0] bit_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q  <= S_IDLE;
            cnt_q    <= 4'h0;
            phase_q  <= 1'b0;
            bit_q    <= 4'h0;
            sample   <= 1'b0;
            dac_code <= 10'h000;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                state_q <= S_IDLE;
                sample  <= 1'b0;
            end else begin
                case (state_q)
                    S_IDLE: begin
                        if (go) begin
                            state_q  <= S_SAMPLE;
                            sample   <= 1'b1;
                            cnt_q    <= level2 ? `SAMPLE_TICKS_N2 : `SAMPLE_TICKS_N1;
                            dac_code <= 10'h000;
                        end
                    end
                    S_SAMPLE: begin
                        if (tick) begin
                            if (cnt_q == 4'h0) begin
                                state_q <= S_BITS;
                                sample  <= 1'b0;
                                bit_q   <= 4'h9;
                                phase_q <= 1'b0;
                            end else begin
                                cnt_q <= cnt_q - 4'h1;
                            end
                        end
                    end
                    S_BITS: begin
                        if (tick) begin
                            phase_q <= ~phase_q;
                            if (!phase_q) begin
                                dac_code[bit_q] <= 1'b1;
                            end else begin
                                // Input below trial level: drop the bit
                                if (!comp_hi) begin
                                    dac_code[bit_q] <= 1'b0;
                                end
                                // 8-bit results stop after bit 2
                                if (bit_q == (res8 ? 4'h2 : 4'h0)) begin
                                    state_q <= S_IDLE;
                                    done    <= 1'b1;
                                end else begin
                                    bit_q <= bit_q - 4'h1;
                                end
                            end
                        end
                    end
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end

endmodule

// File: tb/adc_partner.sv
/* Analog side of adc_ctrl: channel c sits at level {c, ofs}.
   Assumes the bench sets ofs before each start. */
`timescale 1ns/1ps
module adc_partner (
    input  wire logic       SYS_CLK, COMP_ENABLE,
    input  wire logic [4:0] CHANNEL_SEL, ofs,
    input  wire logic [9:0] DAC_CODE,
    output logic            COMP_IN = 1'b0
);
    // A stopped comparator toggles, so a stale answer is never trusted
    always @(posedge SYS_CLK)
        COMP_IN <= COMP_ENABLE ? {CHANNEL_SEL, ofs} > DAC_CODE : ~COMP_IN;
endmodule

// File: tb/adc_ctrl_asserts.sv
/* Port checker of adc_ctrl, bound below.
   Assumes the clock gate register at 12'h020. */
`timescale 1ns/1ps
module adc_ctrl_asserts (
    input wire logic        SYS_CLK, RESET, PSEL, PENABLE, PWRITE, PSLVERR, SAMPLE,
    input wire logic        INTERNAL_SRC, NEG_REF_SEL, COMP_ENABLE, CONV_END_IRQ,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [4:0]  CHANNEL_SEL
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    logic gate_q;
    always @(posedge SYS_CLK or posedge RESET)
        if (RESET) gate_q <= 1'b0;
        else if (PSEL && PENABLE && PWRITE && PADDR == 12'h020) gate_q <= PWDATA[0];
    sequence s_wr(logic [11:0] a, logic g);
        PSEL && PENABLE && PWRITE && PADDR == a && gate_q == g;
    endsequence
    a_err_unmap: assert property (PSEL && PENABLE |->
        PSLVERR == (PADDR > 12'h020 || PADDR[1:0] != 2'h0)) else $error("bad slave error");
    a_irq_pulse: assert property (CONV_END_IRQ |=> !CONV_END_IRQ) else $error("irq long");
    a_neg_wr: assert property (s_wr(12'h008, 1'b1) |=> NEG_REF_SEL == $past(PWDATA[5]))
        else $error("neg ref");
    a_gate_block: assert property (s_wr(12'h008, 1'b0) |=> $stable(NEG_REF_SEL))
        else $error("gated write");
    a_src_wr: assert property (s_wr(12'h014, 1'b1) |=> INTERNAL_SRC == $past(PWDATA[7]))
        else $error("source");
    a_cmp_wr: assert property (s_wr(12'h000, 1'b1) |=> COMP_ENABLE == $past(PWDATA[0]))
        else $error("comparator");
    a_gate_cmp: assert property (s_wr(12'h020, 1'b1) |=>
        COMP_ENABLE == ($past(PWDATA[0]) && $past(COMP_ENABLE))) else $error("gate");
    a_chan_pins: assert property (SAMPLE && !INTERNAL_SRC |->
        CHANNEL_SEL <= 5'h03 || CHANNEL_SEL inside {[5'h10:5'h17]}) else $error("channel");
endmodule
bind adc_ctrl adc_ctrl_asserts i_adc_ctrl_asserts (.SYS_CLK, .RESET, .PSEL, .PENABLE, .PWRITE,
    .PSLVERR, .SAMPLE, .INTERNAL_SRC, .NEG_REF_SEL, .COMP_ENABLE, .CONV_END_IRQ, .PADDR, .PWDATA,
    .CHANNEL_SEL);

// File: tb/test_adc_ctrl.sv
/* Self-checking bench of adc_ctrl: APB master, result model, verdict.
   Assumes adc_partner on the analog side. */
`timescale 1ns/1ps
module test_adc_ctrl;
    logic        SYS_CLK, RESET, PSEL, PENABLE, PWRITE, HW_TRIGGER, err;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, rd, x;
    logic [7:0]  e8, lo;
    logic [4:0]  ofs, chan;
    wire  [31:0] PRDATA;
    wire  [9:0]  DAC_CODE;
    wire  [4:0]  CHANNEL_SEL;
    wire  [1:0]  POS_REF_SEL;
    wire         PREADY, PSLVERR, COMP_IN, INTERNAL_SRC, NEG_REF_SEL, COMP_ENABLE, SAMPLE;
    wire         CONV_END_IRQ;
    int          fails, checks_done, irqs, exp_irqs, cyc, n, k, h;
    adc_ctrl i_adc_ctrl (.SYS_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .HW_TRIGGER, .COMP_IN, .CHANNEL_SEL, .INTERNAL_SRC, .POS_REF_SEL,
        .NEG_REF_SEL, .COMP_ENABLE, .SAMPLE, .DAC_CODE, .CONV_END_IRQ);
    adc_partner i_adc_partner (.SYS_CLK, .COMP_ENABLE, .CHANNEL_SEL, .ofs, .DAC_CODE, .COMP_IN);
    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task automatic chk(input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do @(posedge SYS_CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic print_verdict;
        if (fails == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Hang guard: a full run needs about 5400 cycles
    always @(posedge SYS_CLK) begin
        cyc++;
        if (CONV_END_IRQ === 1'b1) irqs++;
        if (cyc == 60000) begin
            fails++;
            print_verdict;
        end
    end
    initial begin
        RESET = 1'b1;
        {PSEL, PENABLE, PWRITE, HW_TRIGGER, PADDR, PWDATA, ofs} = '0;
        x = 32'd17234;
        repeat (6) @(posedge SYS_CLK);
        RESET <= 1'b0;
        apb(1'b0, 12'h00c, 0);
        chk(rd, 0);
        apb(1'b1, 12'h008, 32'h20);
        apb(1'b1, 12'h020, 1);
        apb(1'b0, 12'h008, 0);
        chk(rd, 0);
        apb(1'b0, 12'h00c, 0);
        chk(rd, 32'hff);
        apb(1'b0, 12'h040, 0);
        chk(err, 1'b1);
        apb(1'b1, 12'h004, 32'h20);
        for (n = 0; n < 8; n++) begin
            x = xs(x);
            ofs <= x[4:0];
            chan = n[2] ? 5'h10 : 5'h10 + x[7:5] % 3'd7;
            e8 = {chan + (n[2] ? 5'h03 : 5'h00), x[4:2]};
            lo = e8 - 8'd4 + (n[1] ? 8'd8 : 8'd0);
            apb(1'b1, 12'h00c, lo + 8'd8);
            apb(1'b1, 12'h010, lo);
            apb(1'b1, 12'h014, chan);
            apb(1'b1, 12'h008, {n[2], 1'b0, n[0], 2'b0, n[1]});
            apb(1'b1, 12'h000, {1'b1, n[2], 6'h19});
            k = 0;
            do apb(1'b0, 12'h000, 0); while (rd[7] === 1'b1 && ++k < 1000);
            chk(rd[7], 1'b0);
            apb(1'b0, 12'h018, 0);
            chk(rd[15:8] + 8'd1 - e8 <= 8'd2, 1'b1);
            if (n[1]) chk(rd[7:0], 0);
            h = (n[2] && n[0]) ? 3 + n[1] : n[0] ^ !n[1];
            exp_irqs += h;
            apb(1'b0, 12'h01c, 0);
            chk(rd[0], h != 0);
            apb(1'b1, 12'h01c, 1);
            chk(irqs, exp_irqs);
        end
        apb(1'b1, 12'h000, 0);
        apb(1'b1, 12'h008, 32'h80);
        repeat (20) @(posedge SYS_CLK);
        apb(1'b1, 12'h00c, 32'hff);
        apb(1'b1, 12'h010, 0);
        apb(1'b1, 12'h004, 32'he0);
        chk(POS_REF_SEL, 2'h2);
        apb(1'b1, 12'h000, 32'h99);
        repeat (200) @(posedge SYS_CLK);
        chk(irqs, exp_irqs);
        HW_TRIGGER <= 1'b1;
        repeat (8) @(posedge SYS_CLK);
        HW_TRIGGER <= 1'b0;
        k = 0;
        do apb(1'b0, 12'h000, 0); while (rd[7] === 1'b1 && ++k < 1000);
        apb(1'b0, 12'h01c, 0);
        chk(rd[0], 1'b1);
        chk(irqs, exp_irqs + 1);
        apb(1'b1, 12'h020, 0);
        print_verdict;
    end
endmodule
